// [design/spim_serial_port.sv]
// shared serial port: spi master and two-wire master behind one register set
// assumes synchronous pins and register requests on the 100 MHz core clock
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - continuous spi streams bytes until the transmit buffer is empty at a byte start.
// - config-two bit 7 selects continuous spi; clear means single-byte transfers.
// - single-byte: buffer write drops select, flag set when empty, select rises.
// - writing the transmit buffer clears the transmit flag.
// - continuous: the flag rises on each load; select releases only when buffer and shifter are empty.
// - without continuous mode, an idle gap separates consecutive bytes.
// - transmit flag rises when the shifter loads from the transmit buffer.
// - transmission stops if no new byte is ready at the next byte start.
// - each spi byte placed in the receive buffer sets status bit 4; a two-wire byte sets bit 5.
// - a spi byte arriving before the previous is read sets overflow, status bit 5.
// - on overflow, config-one bit 2 chooses overwrite or discard.
// - two-wire side is a hardware master only, no slave function.
// - pin owner select picks which personality drives the shared pins.
// - two-wire pins are open drain, wired-and.
// - two-wire transfer: start, address with direction, data on ack, stop.
// - two-wire clock is core clock over 16 shifted left by the rate field.
// - enable bit 7 gates the two-wire side; address write then starts it.
// - address register holds 7-bit target on top, direction in bit 0.
// - a read ends after read count plus one bytes, or on error.
// - both personalities share buffers, mode, address and status registers.
// - direction 1 reads into the receive buffer; 0 writes transmit data.
// - missing acknowledge sets status bit 6 and stops; writing zero clears.
// - spi bytes are eight bits, most significant bit first.
module spim_serial_port (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire spim_pkg::spim_sfr_req_t SFR_REQ,
  output logic [7:0] SFR_RDATA,
  input wire logic PIN_OWNER_SELECT,
  output logic TX_READY,
  output logic SS_N,
  input wire logic MISO_I,
  input wire logic DATA_I,
  output logic DATA_O,
  output logic DATA_OE,
  input wire logic SCLK_I,
  output logic SCLK_O,
  output logic SCLK_OE
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = a == t;
  endfunction : hit

  spim_pkg::spim_state_t st_r;
  logic [7:0] mode_r, tadr_r, stat_r, rx_buf_r, rdata_r;
  logic [7:0] sh_r, rxs_r;
  logic rx_full_r, rd_dir_r, addr_ph_r, ack_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [4:0] div_r, rcnt_r;
  logic ss_n_r, mosi_r, sclk_r, sda_low_r, scl_low_r;
  logic data_o_r, data_oe_r, sclk_o_r, sclk_oe_r;
  logic fifo_vld_w, tx_rdy_w;
  logic [7:0] fifo_data_w;
  logic [2:0] fifo_lvl_w;

  wire twi_w = PIN_OWNER_SELECT;
  wire wr_tx_w = SFR_REQ.wr && hit(SFR_REQ.addr, spim_pkg::ADDR_TXBUF);
  wire wr_mode_w = SFR_REQ.wr && hit(SFR_REQ.addr, spim_pkg::ADDR_MODE);
  wire wr_tadr_w = SFR_REQ.wr && hit(SFR_REQ.addr, spim_pkg::ADDR_TADR);
  wire wr_stat_w = SFR_REQ.wr && hit(SFR_REQ.addr, spim_pkg::ADDR_STAT);
  wire rd_rx_w = SFR_REQ.rd && hit(SFR_REQ.addr, spim_pkg::ADDR_RXBUF);
  // one register pair read as spi config or two-wire mode/address
  wire cont_w = tadr_r[spim_pkg::CONT_BIT];
  wire ovw_w = mode_r[spim_pkg::OVW_BIT];
  wire en_w = mode_r[spim_pkg::EN_BIT];
  wire [1:0] rate_w = mode_r[spim_pkg::RATE_LO +: 2];
  wire [4:0] rct_w = mode_r[spim_pkg::RCT_LO +: 5];

  // quarter-bit length: 16 << rate core clocks per two-wire bit
  wire [5:0] quarter_w = twi_w ? (spim_pkg::TW_QUARTER_BASE << rate_w) : spim_pkg::SPI_QUARTER;
  wire [5:0] qm1_w = quarter_w - 6'h01;
  wire active_w = st_r != spim_pkg::SP_IDLE;
  wire shifting_w = st_r == spim_pkg::SP_SHIFT || st_r == spim_pkg::TW_BYTE;
  // a slave holding the clock low stretches the high phase
  wire stretch_w = twi_w && st_r == spim_pkg::TW_BYTE && ph_r == 2'h1 && !SCLK_I;
  wire tick_w = active_w && div_r == 5'h00 && !stretch_w;
  wire [3:0] last_bit_w = twi_w ? spim_pkg::TW_LAST_BIT : spim_pkg::SPI_LAST_BIT;
  wire byte_end_w = shifting_w && tick_w && ph_r == 2'h3 && bit_r == last_bit_w;
  wire sample_w = twi_w ? DATA_I : MISO_I;
  wire tw_txbyte_w = addr_ph_r || !rd_dir_r;
  wire tw_rdone_w = rcnt_r == rct_w;

  // byte loads only happen at a byte start with data waiting
  wire spi_start_w = st_r == spim_pkg::SP_IDLE && !twi_w && fifo_vld_w;
  wire spi_next_w = !twi_w && byte_end_w && cont_w && fifo_vld_w;
  wire tw_next_w = twi_w && byte_end_w && tw_txbyte_w && !ack_r && !(addr_ph_r && rd_dir_r) && fifo_vld_w;
  wire tx_load_w = spi_start_w || spi_next_w || tw_next_w;
  wire rx_evt_w = byte_end_w && (!twi_w || !tw_txbyte_w);
  wire nack_evt_w = twi_w && byte_end_w && tw_txbyte_w && ack_r;
  wire ovf_w = rx_evt_w && rx_full_r;
  wire rx_place_w = rx_evt_w && (!rx_full_r || ovw_w);
  // two-wire start only when enabled and idle
  wire tw_go_w = twi_w && en_w && wr_tadr_w && st_r == spim_pkg::SP_IDLE;

  wire [7:0] set_w = twi_w
    ? (8'(nack_evt_w) << spim_pkg::NOACK_BIT) | (8'(rx_place_w) << spim_pkg::TW_RX_BIT)
      | (8'(tx_load_w) << spim_pkg::TW_TX_BIT)
    : (8'(ovf_w) << spim_pkg::SPI_OVF_BIT) | (8'(rx_place_w) << spim_pkg::SPI_RX_BIT)
      | (8'(tx_load_w) << spim_pkg::SPI_TX_BIT);
  wire [7:0] clr_w = wr_tx_w ? (8'h01 << (twi_w ? spim_pkg::TW_TX_BIT : spim_pkg::SPI_TX_BIT)) : 8'h00;
  wire [7:0] stat_keep_w = wr_stat_w ? stat_r & SFR_REQ.wdata : stat_r;
  wire [1:0] fstat_w = fifo_lvl_w == 3'(spim_pkg::FIFO_DEPTH) ? spim_pkg::FSTAT_FULL
    : fifo_lvl_w >= spim_pkg::FIFO_HALF_LVL ? spim_pkg::FSTAT_HALF : spim_pkg::FSTAT_EMPTY;
  wire [7:0] tw_view_w = (stat_r & ~((8'h01 << spim_pkg::BUSY_BIT) | (8'h03 << spim_pkg::FSTAT_LO)
    | 8'h01)) | (8'(active_w) << spim_pkg::BUSY_BIT) | (8'(fstat_w) << spim_pkg::FSTAT_LO);
  wire [7:0] spi_view_w = (stat_r & ~(8'h01 << spim_pkg::TXFULL_BIT)) | (8'(!tx_rdy_w) << spim_pkg::TXFULL_BIT);
  wire [7:0] rd_mux_w = hit(SFR_REQ.addr, spim_pkg::ADDR_RXBUF) ? rx_buf_r
    : hit(SFR_REQ.addr, spim_pkg::ADDR_MODE) ? mode_r
    : hit(SFR_REQ.addr, spim_pkg::ADDR_TADR) ? tadr_r
    : hit(SFR_REQ.addr, spim_pkg::ADDR_STAT) ? (twi_w ? tw_view_w : spi_view_w)
    : spim_pkg::RESET_BYTE;

  spim_fifo #(
    .WIDTH(spim_pkg::DATA_W),
    .DEPTH(spim_pkg::FIFO_DEPTH)
  ) u_txq (
    .clk(CORE_CLK),
    .rst(RST),
    .in_valid(wr_tx_w),
    .in_ready(tx_rdy_w),
    .in_data(SFR_REQ.wdata),
    .out_valid(fifo_vld_w),
    .out_ready(tx_load_w),
    .out_data(fifo_data_w),
    .level(fifo_lvl_w)
  );

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      mode_r <= spim_pkg::RESET_BYTE;
      tadr_r <= spim_pkg::RESET_BYTE;
      stat_r <= spim_pkg::RESET_BYTE;
      rdata_r <= spim_pkg::RESET_BYTE;
    end
    else
    begin
      mode_r <= wr_mode_w ? SFR_REQ.wdata : mode_r;
      tadr_r <= wr_tadr_w ? SFR_REQ.wdata : tadr_r;
      // hardware set wins over a same-cycle clear
      stat_r <= (stat_keep_w & ~clr_w) | set_w;
      rdata_r <= SFR_REQ.rd ? rd_mux_w : rdata_r;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      rx_buf_r <= spim_pkg::RESET_BYTE;
      rx_full_r <= 1'b0;
    end
    else
    begin
      rx_buf_r <= rx_place_w ? rxs_r : rx_buf_r;
      rx_full_r <= rx_evt_w || (rx_full_r && !rd_rx_w);
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST || !active_w || tick_w)
    begin
      div_r <= qm1_w[4:0];
    end
    else if (div_r != 5'h00)
    begin
      div_r <= div_r - 5'h01;
    end
  end

  // one engine serves both personalities; the phase counter walks each bit
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      st_r <= spim_pkg::SP_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= spim_pkg::RESET_BYTE;
      rxs_r <= spim_pkg::RESET_BYTE;
      rd_dir_r <= 1'b0;
      addr_ph_r <= 1'b0;
      ack_r <= 1'b0;
      rcnt_r <= 5'h00;
      ss_n_r <= 1'b1;
      mosi_r <= 1'b0;
      sclk_r <= 1'b0;
      sda_low_r <= 1'b0;
      scl_low_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        spim_pkg::SP_IDLE:
        begin
          ph_r <= 2'h0;
          bit_r <= 4'h0;
          sda_low_r <= 1'b0;
          scl_low_r <= 1'b0;
          if (spi_start_w)
          begin
            st_r <= spim_pkg::SP_SHIFT;
            ss_n_r <= 1'b0;
            sh_r <= fifo_data_w;
            mosi_r <= fifo_data_w[7];
          end
          else if (tw_go_w)
          begin
            st_r <= spim_pkg::TW_START;
            sh_r <= SFR_REQ.wdata;
            rd_dir_r <= SFR_REQ.wdata[spim_pkg::DIR_BIT];
            addr_ph_r <= 1'b1;
            rcnt_r <= 5'h00;
          end
        end
        spim_pkg::SP_SHIFT, spim_pkg::TW_BYTE:
        begin
          if (tick_w)
          begin
            ph_r <= ph_r + 2'h1;
            unique case (ph_r)
              2'h0:
              begin
                sclk_r <= 1'b1;
                scl_low_r <= 1'b0;
              end
              2'h1:
              begin
                if (bit_r < spim_pkg::TW_LAST_BIT)
                begin
                  rxs_r <= {rxs_r[6:0], sample_w};
                end
                else
                begin
                  ack_r <= sample_w;
                end
              end
              2'h2:
              begin
                sclk_r <= 1'b0;
                scl_low_r <= 1'b1;
              end
              2'h3:
              begin
                if (!byte_end_w)
                begin
                  bit_r <= bit_r + 4'h1;
                  if (bit_r == spim_pkg::TW_ACK_PREV)
                  begin
                    // master acks every read byte but the last
                    sda_low_r <= !tw_txbyte_w && !tw_rdone_w;
                  end
                  else
                  begin
                    sh_r <= {sh_r[6:0], 1'b0};
                    mosi_r <= sh_r[6];
                    sda_low_r <= tw_txbyte_w && !sh_r[6];
                  end
                end
                else
                begin
                  bit_r <= 4'h0;
                  if (tx_load_w)
                  begin
                    sh_r <= fifo_data_w;
                    mosi_r <= fifo_data_w[7];
                    sda_low_r <= !fifo_data_w[7];
                    addr_ph_r <= 1'b0;
                  end
                  else if (!twi_w)
                  begin
                    ss_n_r <= 1'b1;
                    st_r <= cont_w ? spim_pkg::SP_IDLE : spim_pkg::SP_GAP;
                  end
                  else if (addr_ph_r && rd_dir_r && !ack_r)
                  begin
                    addr_ph_r <= 1'b0;
                    sda_low_r <= 1'b0;
                  end
                  else if (!tw_txbyte_w && !tw_rdone_w)
                  begin
                    rcnt_r <= rcnt_r + 5'h01;
                    sda_low_r <= 1'b0;
                  end
                  else
                  begin
                    st_r <= spim_pkg::TW_STOP;
                    sda_low_r <= 1'b1;
                  end
                end
              end
            endcase
          end
        end
        spim_pkg::SP_GAP:
        begin
          if (tick_w)
          begin
            bit_r <= bit_r + 4'h1;
            if (bit_r == spim_pkg::SPI_GAP_TICKS - 4'h1)
            begin
              st_r <= spim_pkg::SP_IDLE;
            end
          end
        end
        spim_pkg::TW_START:
        begin
          if (tick_w)
          begin
            ph_r <= ph_r + 2'h1;
            sda_low_r <= ph_r == 2'h3 ? !sh_r[7] : (sda_low_r || ph_r == 2'h0);
            scl_low_r <= scl_low_r || ph_r == 2'h1;
            if (ph_r == 2'h3)
            begin
              st_r <= spim_pkg::TW_BYTE;
            end
          end
        end
        spim_pkg::TW_STOP:
        begin
          if (tick_w)
          begin
            ph_r <= ph_r + 2'h1;
            scl_low_r <= scl_low_r && ph_r != 2'h0;
            sda_low_r <= sda_low_r && ph_r != 2'h1;
            if (ph_r == 2'h3)
            begin
              st_r <= spim_pkg::SP_IDLE;
            end
          end
        end
        default:
        begin
          st_r <= spim_pkg::SP_IDLE;
        end
      endcase
    end
  end

  // pin stage: two-wire only ever pulls low, spi drives push-pull
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      data_o_r <= 1'b0;
      data_oe_r <= 1'b0;
      sclk_o_r <= 1'b0;
      sclk_oe_r <= 1'b0;
    end
    else
    begin
      data_o_r <= !twi_w && mosi_r;
      data_oe_r <= twi_w ? sda_low_r : 1'b1;
      sclk_o_r <= !twi_w && sclk_r;
      sclk_oe_r <= twi_w ? scl_low_r : 1'b1;
    end
  end

  assign SFR_RDATA = rdata_r;
  assign TX_READY = tx_rdy_w;
  assign SS_N = ss_n_r;
  assign DATA_O = data_o_r;
  assign DATA_OE = data_oe_r;
  assign SCLK_O = sclk_o_r;
  assign SCLK_OE = sclk_oe_r;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_tx_flag_load;
    tx_load_w && !twi_w |=> stat_r[spim_pkg::SPI_TX_BIT];
  endproperty
  a_tx_flag_load: assert property (p_tx_flag_load) else $error("tx flag not set on load");

  property p_tx_write_clear;
    wr_tx_w && !tx_load_w && !twi_w |=> !stat_r[spim_pkg::SPI_TX_BIT];
  endproperty
  a_tx_write_clear: assert property (p_tx_write_clear) else $error("tx flag not cleared");

  property p_rx_place;
    rx_place_w && !twi_w |=> stat_r[spim_pkg::SPI_RX_BIT] && rx_buf_r == $past(rxs_r);
  endproperty
  a_rx_place: assert property (p_rx_place) else $error("rx byte or flag wrong");

  property p_rx_overflow;
    ovf_w && !twi_w |=> stat_r[spim_pkg::SPI_OVF_BIT];
  endproperty
  a_rx_overflow: assert property (p_rx_overflow) else $error("overflow not flagged");

  property p_rx_discard;
    rx_evt_w && rx_full_r && !ovw_w |=> $stable(rx_buf_r);
  endproperty
  a_rx_discard: assert property (p_rx_discard) else $error("old byte overwritten");

  property p_gap;
    !twi_w && byte_end_w && !cont_w && !fifo_vld_w |=> (st_r == spim_pkg::SP_GAP && SS_N) [*4];
  endproperty
  a_gap: assert property (p_gap) else $error("no idle gap");

  property p_stream;
    spi_next_w |=> st_r == spim_pkg::SP_SHIFT && !ss_n_r && bit_r == 4'h0;
  endproperty
  a_stream: assert property (p_stream) else $error("stream broken");

  property p_tw_start;
    tw_go_w |=> st_r == spim_pkg::TW_START ##1 !sda_low_r;
  endproperty
  a_tw_start: assert property (p_tw_start) else $error("two-wire start missed");

  property p_tw_start_cond;
    st_r == spim_pkg::TW_START && tick_w && ph_r == 2'h0 |=> sda_low_r && !scl_low_r;
  endproperty
  a_tw_start_cond: assert property (p_tw_start_cond) else $error("start condition wrong");

  property p_tw_stop_cond;
    st_r == spim_pkg::TW_STOP && tick_w && ph_r == 2'h1 |=> !sda_low_r && !scl_low_r;
  endproperty
  a_tw_stop_cond: assert property (p_tw_stop_cond) else $error("stop condition wrong");

  property p_noack;
    nack_evt_w |=> stat_r[spim_pkg::NOACK_BIT] && st_r == spim_pkg::TW_STOP;
  endproperty
  a_noack: assert property (p_noack) else $error("missing ack not handled");
endmodule : spim_serial_port
`default_nettype wire

// [design/spim_pkg.sv]
// constants and types for the shared spi / two-wire master serial port
// assumes an 8-bit special-function register port and one 100 MHz core clock
package spim_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  // register addresses
  localparam logic [7:0] ADDR_TXBUF = 8'h9A;
  localparam logic [7:0] ADDR_RXBUF = 8'h9B;
  localparam logic [7:0] ADDR_MODE = 8'hE8;
  localparam logic [7:0] ADDR_TADR = 8'hE9;
  localparam logic [7:0] ADDR_STAT = 8'hEA;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // field positions in mode / address registers
  localparam int CONT_BIT = 7;
  localparam int OVW_BIT = 2;
  localparam int EN_BIT = 7;
  localparam int RATE_LO = 5;
  localparam int RCT_LO = 0;
  localparam int DIR_BIT = 0;
  // status bit positions
  localparam int TXFULL_BIT = 0;
  localparam int SPI_TX_BIT = 1;
  localparam int FSTAT_LO = 2;
  localparam int TW_TX_BIT = 4;
  localparam int SPI_RX_BIT = 4;
  localparam int SPI_OVF_BIT = 5;
  localparam int TW_RX_BIT = 5;
  localparam int NOACK_BIT = 6;
  localparam int BUSY_BIT = 7;
  localparam logic [1:0] FSTAT_EMPTY = 2'h0;
  localparam logic [1:0] FSTAT_HALF = 2'h2;
  localparam logic [1:0] FSTAT_FULL = 2'h3;
  localparam logic [2:0] FIFO_HALF_LVL = 3'h2;
  // timing: one bit is four quarter ticks
  localparam int TW_BASE_DIV = 16;
  localparam logic [5:0] TW_QUARTER_BASE = 6'(TW_BASE_DIV / 4);
  localparam logic [5:0] SPI_QUARTER = 6'h2;
  localparam logic [3:0] SPI_GAP_TICKS = 4'h4;
  localparam logic [3:0] SPI_LAST_BIT = 4'h7;
  localparam logic [3:0] TW_LAST_BIT = 4'h8;
  localparam logic [3:0] TW_ACK_PREV = 4'h7;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spim_sfr_req_t;

  typedef enum logic [2:0]
  {
    SP_IDLE = 3'b000,
    SP_SHIFT = 3'b001,
    SP_GAP = 3'b010,
    TW_START = 3'b011,
    TW_BYTE = 3'b100,
    TW_STOP = 3'b101
  } spim_state_t;
endpackage : spim_pkg

// [design/spim_fifo.sv]
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module spim_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  logic ready_r;
  wire push_w = in_valid && ready_r;
  wire pop_w = out_ready && cnt_r != '0;
  wire [PW:0] cnt_nxt = cnt_r + (PW+1)'(push_w) - (PW+1)'(pop_w);

  always_ff @(posedge clk)
  begin
    if (push_w)
    begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
    end
    else
    begin
      wp_r <= push_w ? wp_r + PW'(1) : wp_r;
      rp_r <= pop_w ? rp_r + PW'(1) : rp_r;
      cnt_r <= cnt_nxt;
      ready_r <= cnt_nxt != (PW+1)'(DEPTH);
    end
  end

  // ready comes from a flop so the source sees back-pressure without a comb path
  assign in_ready = ready_r;
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign level = cnt_r;
endmodule : spim_fifo
`default_nettype wire

// [sim/spim_far_side.sv]
// far side: spi slave echoing the previous byte, two-wire slave
// assumes registered pins from the port and pull-ups on both wires
`timescale 1ns/100ps
`default_nettype none
module spim_far_side #(
  parameter logic [6:0] TW_ADDR = 7'h2B,
  parameter logic [7:0] TW_RDATA = 8'hC3
) (
  input wire logic OWNER,
  input wire logic SS_N,
  input wire logic SCLK_O,
  input wire logic SCLK_OE,
  input wire logic DATA_O,
  input wire logic DATA_OE,
  output logic MISO,
  output logic SDA,
  output logic SCL
);
  logic [7:0] sh = 8'h00, rx = 8'h00, last = 8'h5A, sr = 8'h00, wbyte = 8'h00;
  logic [3:0] cnt = 4'h0, bc = 4'h0;
  logic act = 1'b0, rdir = 1'b0, first = 1'b0, ok = 1'b0, pull = 1'b0;
  int got = 0, rds = 0;
  // deselected miso shows the inverse so a stale bit never passes
  assign MISO = SS_N ? ~sh[7] : sh[7];
  assign SDA = ~(OWNER & ((DATA_OE & ~DATA_O) | pull));
  assign SCL = ~(OWNER & SCLK_OE & ~SCLK_O);
  always @(negedge SS_N) sh = last;
  always @(posedge SS_N) cnt = 4'h0;
  always @(posedge SCLK_O)
  begin
    if (!OWNER && !SS_N)
    begin
      rx = {rx[6:0], DATA_O};
      cnt = cnt + 4'h1;
      if (cnt == 4'h8)
      begin
        cnt = 4'h0;
        last = rx;
        got = got + 1;
      end
    end
  end
  // next bit out on the falling edge, msb first
  always @(negedge SCLK_O)
  begin
    if (!OWNER && !SS_N)
      sh = (cnt == 4'h0) ? last : {sh[6:0], 1'b0};
  end
  always @(negedge SDA)
  begin
    if (SCL)
    begin
      act = 1'b1;
      bc = 4'h0;
      first = 1'b1;
    end
  end
  always @(posedge SDA) if (SCL) act = 1'b0;
  always @(posedge SCL)
  begin
    if (act)
    begin
      if (bc < 4'h8) sr = {sr[6:0], SDA};
      bc = (bc == 4'h8) ? 4'h0 : bc + 4'h1;
    end
  end
  // the wire only changes while the clock is low
  always @(negedge SCL)
  begin
    if (act && ok && rdir && !first && bc == 4'h8) rds = rds + 1;
    if (!act)
      pull = 1'b0;
    else if (bc == 4'h8 && first)
    begin
      rdir = sr[0];
      ok = (sr[7:1] == TW_ADDR);
      pull = ok;
      first = 1'b0;
    end
    else if (bc == 4'h8 && !rdir && ok)
    begin
      wbyte = sr;
      pull = 1'b1;
    end
    else
      pull = ok && rdir && !first && bc < 4'h8 && !TW_RDATA[4'h7 - bc];
  end
endmodule : spim_far_side
`default_nettype wire

// [sim/spim_serial_port_tb.sv]
// bench for the shared spi / two-wire master port
// assumes spim_far_side stands as the slaves on the pins
`timescale 1ns/100ps
`default_nettype none
module spim_serial_port_tb;
  localparam logic [6:0] GOOD = 7'h2B;
  localparam logic [7:0] TX = spim_pkg::ADDR_TXBUF;
  localparam logic [7:0] RX = spim_pkg::ADDR_RXBUF;
  localparam logic [7:0] MD = spim_pkg::ADDR_MODE;
  localparam logic [7:0] TA = spim_pkg::ADDR_TADR;
  localparam logic [7:0] ST = spim_pkg::ADDR_STAT;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic owner = 1'b0;
  spim_pkg::spim_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata, rv;
  logic tx_ready, ss_n, miso, sda, scl, data_o, data_oe, sclk_o, sclk_oe;
  int errors = 0, comparisons = 0, n, g;
  time t0;
  always #5 core_clk = ~core_clk;
  spim_serial_port dut (.CORE_CLK(core_clk), .RST(rst), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata),
    .PIN_OWNER_SELECT(owner), .TX_READY(tx_ready), .SS_N(ss_n), .MISO_I(miso), .DATA_I(sda),
    .DATA_O(data_o), .DATA_OE(data_oe), .SCLK_I(scl), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe));
  spim_far_side #(.TW_ADDR(GOOD), .TW_RDATA(8'hC3)) far (.OWNER(owner), .SS_N(ss_n), .SCLK_O(sclk_o),
    .SCLK_OE(sclk_oe), .DATA_O(data_o), .DATA_OE(data_oe), .MISO(miso), .SDA(sda), .SCL(scl));
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_req = '{a, d, 1'b1, 1'b0};
    @(negedge core_clk);
    sfr_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    sfr_req = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge core_clk);
    sfr_req.rd = 1'b0;
    @(negedge core_clk);
    rv = sfr_rdata;
  endtask : rd
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    rd(a);
    chk(what, exp, rv & m);
  endtask : rchk
  task automatic wait_ss(input logic v);
    n = 0;
    while (ss_n !== v && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("select", {7'h00, v}, {7'h00, ss_n});
  endtask : wait_ss
  task automatic wait_idle();
    n = 0;
    do
    begin
      rd(ST);
      n++;
    end
    while (rv[7] !== 1'b0 && n < 2000);
    chk("busy", 8'h00, rv & 8'h80);
  endtask : wait_idle
  task automatic t_reset();
    chk("tx ready", 8'h01, {7'h00, tx_ready});
    rchk("mode", MD, 8'hFF, 8'h00);
    rchk("target", TA, 8'hFF, 8'h00);
    rchk("status", ST, 8'hFF, 8'h00);
    rchk("rx", RX, 8'hFF, 8'h00);
    rchk("unmapped", 8'h55, 8'hFF, 8'h00);
    wr(MD, 8'h04);
    rchk("mode rw", MD, 8'hFF, 8'h04);
  endtask : t_reset
  task automatic t_spi_single();
    wr(TA, 8'h00);
    wr(TX, 8'hA5);
    wait_ss(1'b0);
    rchk("tx flag", ST, 8'h02, 8'h02);
    wait_ss(1'b1);
    chk("slave byte", 8'hA5, far.last);
    rchk("rx flag", ST, 8'h10, 8'h10);
    rchk("rx data", RX, 8'hFF, 8'h5A);
    wr(ST, 8'h00);
  endtask : t_spi_single
  task automatic t_spi_gap();
    wr(MD, 8'h00);
    wr(TX, 8'h12);
    wait_ss(1'b0);
    wr(TX, 8'h34);
    rchk("tx flag clear", ST, 8'h02, 8'h00);
    wait_ss(1'b1);
    n = 0;
    while (ss_n === 1'b1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("gap", 8'h01, {7'h00, n >= int'(spim_pkg::SPI_GAP_TICKS) * int'(spim_pkg::SPI_QUARTER)});
    wait_ss(1'b1);
    rchk("overflow", ST, 8'h20, 8'h20);
    rchk("discard", RX, 8'hFF, 8'hA5);
    chk("slave byte", 8'h34, far.last);
    wr(ST, 8'h00);
  endtask : t_spi_gap
  task automatic t_spi_cont();
    wr(MD, 8'h04);
    wr(TA, 8'h80);
    wr(TX, 8'h9C);
    wr(TX, 8'h3E);
    wait_ss(1'b0);
    g = far.got;
    n = 0;
    while (ss_n === 1'b0 && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("stream bytes", 8'h02, 8'(far.got - g));
    rchk("tx flag end", ST, 8'h02, 8'h02);
    rchk("overwrite", RX, 8'hFF, 8'h9C);
    repeat (200) @(negedge core_clk);
    chk("stopped", 8'h00, 8'(far.got - g - 2));
    wr(TA, 8'h00);
    wr(ST, 8'h00);
  endtask : t_spi_cont
  task automatic t_tw_rates();
    owner = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      wr(MD, 8'h80 | 8'(r << 5));
      wr(TA, {7'h11, 1'b0});
      @(posedge scl);
      t0 = $time;
      @(posedge scl);
      chk("scl period", 8'(16 << r), 8'(($time - t0) / 10));
      wait_idle();
      rchk("no ack", ST, 8'h40, 8'h40);
      wr(ST, 8'h00);
      rchk("no ack clear", ST, 8'h40, 8'h00);
    end
    chk("spi idle", 8'h01, {7'h00, ss_n});
    chk("open drain", 8'h00, {6'h00, data_o, sclk_o});
  endtask : t_tw_rates
  task automatic t_tw_xfer();
    wr(MD, 8'h00);
    wr(TA, {GOOD, 1'b0});
    rchk("disabled", ST, 8'h80, 8'h00);
    wr(MD, 8'h80);
    wr(TX, 8'h11);
    wr(TX, 8'h22);
    wr(TX, 8'h33);
    wr(TX, 8'h81);
    chk("tx full", 8'h00, {7'h00, tx_ready});
    rchk("fifo level", ST, 8'h0C, 8'h0C);
    wr(TX, 8'h55);
    wr(TA, {GOOD, 1'b0});
    wait_idle();
    chk("written byte", 8'h81, far.wbyte);
    rchk("acked", ST, 8'h40, 8'h00);
    g = far.rds;
    wr(MD, 8'h81);
    wr(TA, {GOOD, 1'b1});
    wait_idle();
    chk("read count", 8'h02, 8'(far.rds - g));
    rchk("tw rx flag", ST, 8'h20, 8'h20);
    rchk("read byte", RX, 8'hFF, 8'hC3);
  endtask : t_tw_xfer
  // reckoned at about ten times the expected run, slowest rate included
  initial
  begin
    repeat (60000) @(posedge core_clk);
    errors++;
    end_sim();
  end
  initial
  begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_spi_single();
    t_spi_gap();
    t_spi_cont();
    t_tw_rates();
    t_tw_xfer();
    end_sim();
  end
endmodule : spim_serial_port_tb
`default_nettype wire
